// ---- hdl/srap_port.sv ----
`timescale 1ns/1ps
// Summary of operation
// - command register is 8 bits, write only; reads hit the shared-address register
// - command byte picks transfer direction and target register
// - after the selected transfer completes, interface goes back to idle, or to SRAP_CONT while continuous readout is on
// - after power-up or reset interface waits idle for a command
// - 40 consecutive ones on input resets whole part and interface
// - command byte shifts msb first, bit 7 first on the line
// - all command bits reset to zero
// - control and configuration live only in on-chip registers, set means 1
// - a leading one is ignored until a zero arrives, then seven more bits load
// - direction 0 writes the register, 1 reads it
// - continuous readout streams each result after done, enter 5C, exit 58 when done low
module srap_port
   import srap_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic sclk, // serial clock pin
   input wire logic din, // serial data in pin
   output logic dout, // serial data out pin
   output logic rdy_n, // conversion done, low while a result waits
   input wire srap_result_s result_in, // new conversion result, same clock
   output logic [23:0] mode_out, // mode register contents
   output logic [23:0] config_out, // configuration register contents
   output logic [7:0] gpout_out, // general output control contents
   output logic [23:0] zcal_out, // zero calibration contents
   output logic [23:0] gcal_out, // gain calibration contents
   output logic part_reset // one-cycle pulse, whole part reset
);
   // ************************************************************
   // pin synchronisers and edge finding
   // ************************************************************
   logic [1:0] sclk_sync_reg, sclk_sync_next;
   logic [1:0] din_sync_reg, din_sync_next;
   logic sclk_last_reg, sclk_last_next;
   logic rise, fall, din_s;

   always_comb begin
      sclk_sync_next = {sclk_sync_reg[0], sclk};
      din_sync_next = {din_sync_reg[0], din};
      sclk_last_next = sclk_sync_reg[1];
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_sync_reg <= 2'h3;
         din_sync_reg <= 2'h3;
         sclk_last_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= sclk_sync_next;
         din_sync_reg <= din_sync_next;
         sclk_last_reg <= sclk_last_next;
      end
   end

   assign rise = sclk_sync_reg[1] & ~sclk_last_reg;
   assign fall = ~sclk_sync_reg[1] & sclk_last_reg;
   assign din_s = din_sync_reg[1];

   function automatic logic is_long(input logic [2:0] sel);
      is_long = (sel == SRAP_ADDR_MODE) || (sel == SRAP_ADDR_CONFIG) || (sel == SRAP_ADDR_RESULT) ||
                (sel == SRAP_ADDR_ZCAL) || (sel == SRAP_ADDR_GCAL);
   endfunction : is_long

   // ************************************************************
   // serial state machine and registers
   // ************************************************************
   srap_state_e state_reg, state_next;
   srap_cmd_s cmd_reg, cmd_next;
   logic [23:0] shift_reg, shift_next;
   logic [4:0] count_reg, count_next;
   logic [5:0] ones_reg, ones_next;
   logic cont_reg, cont_next;
   logic [23:0] mode_reg, mode_next, config_reg, config_next, zcal_reg, zcal_next, gcal_reg, gcal_next;
   logic [23:0] result_reg, result_next;
   logic [7:0] gpout_reg, gpout_next;
   logic rdy_n_reg, rdy_n_next;
   logic dout_reg, dout_next;
   logic preset;
   logic [7:0] cmd_byte;
   logic [4:0] width;

   assign cmd_byte = {shift_reg[6:0], din_s};
   assign preset = rise && din_s && (ones_reg == SRAP_RESET_ONES - 6'h01);
   assign width = is_long(cmd_reg.sel) ? SRAP_LONG_BITS : SRAP_CMD_BITS;

   // ************************************************************
   // command watch while streaming results
   // ************************************************************
   logic [7:0] watch_reg, watch_next;
   logic exit_seen;

   always_comb begin
      watch_next = watch_reg;
      if (state_reg == SRAP_READ && rise) begin
         watch_next = {watch_reg[6:0], din_s};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || preset) begin
         watch_reg <= 8'h00;
      end else begin
         watch_reg <= watch_next;
      end
   end

   // exit command seen on the eighth data rise of a streamed read
   assign exit_seen = (state_reg == SRAP_READ) && cont_reg && rise && (count_reg == SRAP_CMD_BITS)
                      && (watch_next == SRAP_CMD_CONT_EXIT);

   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      shift_next = shift_reg;
      count_next = count_reg;
      cont_next = cont_reg;
      mode_next = mode_reg;
      config_next = config_reg;
      zcal_next = zcal_reg;
      gcal_next = gcal_reg;
      gpout_next = gpout_reg;
      result_next = result_reg;
      rdy_n_next = rdy_n_reg;
      dout_next = dout_reg;
      ones_next = ones_reg;
      if (rise) begin
         ones_next = din_s ? ones_reg + 6'h01 : 6'h00;
      end
      if (result_in.valid) begin
         result_next = result_in.data;
         rdy_n_next = 1'b0;
      end
      case (state_reg)
         SRAP_IDLE, SRAP_CONT: begin
            if (rise && !din_s) begin
               state_next = SRAP_CMD;
               shift_next = 24'h000000;
               count_next = 5'h01;
            end else if (state_reg == SRAP_CONT && fall && !rdy_n_reg) begin
               state_next = SRAP_READ;
               cmd_next.sel = SRAP_ADDR_RESULT;
               cmd_next.dir = 1'b1;
               shift_next = result_reg;
               count_next = 5'h01; // msb already loaded
               dout_next = result_reg[23];
            end
         end
         SRAP_CMD: begin
            if (rise) begin
               shift_next = {16'h0000, cmd_byte};
               count_next = count_reg + 5'h01;
               if (count_reg == SRAP_CMD_BITS - 5'h01) begin
                  cmd_next = srap_cmd_s'(cmd_byte);
                  count_next = 5'h00;
                  if (cmd_byte == SRAP_CMD_CONT_ENTER) begin
                     cont_next = 1'b1;
                     state_next = SRAP_CONT;
                  end else if (cmd_byte == SRAP_CMD_CONT_EXIT && cont_reg && !rdy_n_reg) begin
                     cont_next = 1'b0;
                     state_next = SRAP_IDLE;
                  end else if (cmd_byte[SRAP_CMD_DIR_BIT]) begin
                     state_next = SRAP_READ;
                  end else begin
                     state_next = SRAP_WRITE;
                  end
               end
            end
         end
         SRAP_WRITE: begin
            if (rise) begin
               shift_next = {shift_reg[22:0], din_s};
               count_next = count_reg + 5'h01;
               if (count_reg == width - 5'h01) begin
                  state_next = cont_reg ? SRAP_CONT : SRAP_IDLE;
                  if (cmd_reg.sel == SRAP_ADDR_MODE) mode_next = {shift_reg[22:0], din_s};
                  else if (cmd_reg.sel == SRAP_ADDR_CONFIG) config_next = {shift_reg[22:0], din_s};
                  else if (cmd_reg.sel == SRAP_ADDR_GPOUT) gpout_next = {shift_reg[6:0], din_s};
                  else if (cmd_reg.sel == SRAP_ADDR_ZCAL) zcal_next = {shift_reg[22:0], din_s};
                  else if (cmd_reg.sel == SRAP_ADDR_GCAL) gcal_next = {shift_reg[22:0], din_s};
               end
            end
         end
         SRAP_READ: begin
            if (exit_seen) begin
               cont_next = 1'b0;
            end
            if (fall) begin
               count_next = count_reg + 5'h01;
               if (count_reg == 5'h00) begin
                  if (cmd_reg.sel == SRAP_ADDR_STATUS) shift_next = {rdy_n_reg, 7'h00, 16'h0000};
                  else if (cmd_reg.sel == SRAP_ADDR_MODE) shift_next = mode_reg;
                  else if (cmd_reg.sel == SRAP_ADDR_CONFIG) shift_next = config_reg;
                  else if (cmd_reg.sel == SRAP_ADDR_RESULT) shift_next = result_reg;
                  else if (cmd_reg.sel == SRAP_ADDR_IDENT) shift_next = {SRAP_IDENT_VAL, 16'h0000};
                  else if (cmd_reg.sel == SRAP_ADDR_GPOUT) shift_next = {gpout_reg, 16'h0000};
                  else if (cmd_reg.sel == SRAP_ADDR_ZCAL) shift_next = zcal_reg;
                  else shift_next = gcal_reg;
                  if (!is_long(cmd_reg.sel)) shift_next = {shift_next[23:16], 16'h0000};
                  dout_next = shift_next[23];
               end else begin
                  shift_next = {shift_reg[22:0], 1'b0};
                  dout_next = shift_reg[22];
               end
            end
            if (rise && count_reg == width) begin
               state_next = (cont_reg && !exit_seen) ? SRAP_CONT : SRAP_IDLE;
               dout_next = 1'b1;
               // a result arriving in the same cycle keeps the flag low
               if (cmd_reg.sel == SRAP_ADDR_RESULT && !result_in.valid) rdy_n_next = 1'b1;
            end
         end
         default: state_next = SRAP_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst || preset) begin
         state_reg <= SRAP_IDLE;
         cmd_reg <= SRAP_RST_CMD;
         shift_reg <= 24'h000000;
         count_reg <= 5'h00;
         ones_reg <= 6'h00;
         cont_reg <= 1'b0;
         mode_reg <= SRAP_RST_MODE;
         config_reg <= SRAP_RST_CONFIG;
         zcal_reg <= SRAP_RST_ZCAL;
         gcal_reg <= SRAP_RST_GCAL;
         gpout_reg <= SRAP_RST_GPOUT;
         result_reg <= SRAP_RST_RESULT;
         rdy_n_reg <= SRAP_RST_STATUS[SRAP_STATUS_RDY_BIT];
         dout_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         shift_reg <= shift_next;
         count_reg <= count_next;
         ones_reg <= ones_next;
         cont_reg <= cont_next;
         mode_reg <= mode_next;
         config_reg <= config_next;
         zcal_reg <= zcal_next;
         gcal_reg <= gcal_next;
         gpout_reg <= gpout_next;
         result_reg <= result_next;
         rdy_n_reg <= rdy_n_next;
         dout_reg <= dout_next;
      end
   end

   assign dout = dout_reg;
   assign rdy_n = rdy_n_reg;
   assign mode_out = mode_reg;
   assign config_out = config_reg;
   assign gpout_out = gpout_reg;
   assign zcal_out = zcal_reg;
   assign gcal_out = gcal_reg;
   assign part_reset = preset;

   // ************************************************************
   // checks
   // ************************************************************
   chk_reset_idle: assert property (@(posedge mclk) rst |=> state_reg == SRAP_IDLE)
      else $error("not idle after reset");
   chk_ones_reset: assert property (@(posedge mclk) disable iff (rst) preset |=> state_reg == SRAP_IDLE && !cont_reg)
      else $error("ones did not reset part");
   chk_lead_one: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_IDLE && rise && din_s) |=> state_reg == SRAP_IDLE)
      else $error("leading one not ignored");
   chk_cmd_defaults: assert property (@(posedge mclk) $fell(rst) |-> cmd_reg == SRAP_RST_CMD)
      else $error("command not cleared");
   chk_dir_read: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_CMD && rise && count_reg == 5'h07 && shift_reg[5]
       && {shift_reg[6:0], din_s} != SRAP_CMD_CONT_ENTER
       && !({shift_reg[6:0], din_s} == SRAP_CMD_CONT_EXIT && cont_reg && !rdy_n_reg)) |=> state_reg == SRAP_READ)
      else $error("read not entered");
   chk_dir_write: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_CMD && rise && count_reg == 5'h07 && !shift_reg[5]) |=> state_reg == SRAP_WRITE)
      else $error("write not entered");
   chk_write_done: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_WRITE && rise && count_reg == width - 5'h01) |=> state_reg != SRAP_WRITE)
      else $error("no return after write");
   chk_read_done: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_READ && rise && count_reg == width)
      |=> state_reg == SRAP_IDLE || state_reg == SRAP_CONT)
      else $error("no return after read");
   chk_cont_enter: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_CMD && rise && count_reg == 5'h07 && {shift_reg[6:0], din_s} == SRAP_CMD_CONT_ENTER)
      |=> cont_reg && state_reg == SRAP_CONT)
      else $error("continuous readout not entered");
   chk_cont_first: assert property (@(posedge mclk) disable iff (rst || preset)
      (state_reg == SRAP_CONT && fall && !rdy_n_reg) |=> state_reg == SRAP_READ && count_reg == 5'h01)
      else $error("streamed read misaligned");
   chk_cont_exit: assert property (@(posedge mclk) disable iff (rst || preset)
      exit_seen |=> !cont_reg)
      else $error("continuous readout not left");
   chk_rdy_set: assert property (@(posedge mclk) disable iff (rst || preset)
      result_in.valid |=> !rdy_n_reg)
      else $error("new result not flagged");
   chk_width_limit: assert property (@(posedge mclk) disable iff (rst) count_reg <= SRAP_LONG_BITS)
      else $error("bit count overrun");
endmodule : srap_port

// ---- hdl/srap_pkg.sv ----
package srap_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [2:0] SRAP_ADDR_STATUS = 3'h0;
   localparam logic [2:0] SRAP_ADDR_MODE = 3'h1;
   localparam logic [2:0] SRAP_ADDR_CONFIG = 3'h2;
   localparam logic [2:0] SRAP_ADDR_RESULT = 3'h3;
   localparam logic [2:0] SRAP_ADDR_IDENT = 3'h4;
   localparam logic [2:0] SRAP_ADDR_GPOUT = 3'h5;
   localparam logic [2:0] SRAP_ADDR_ZCAL = 3'h6;
   localparam logic [2:0] SRAP_ADDR_GCAL = 3'h7;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] SRAP_RST_CMD = 8'h00;
   localparam logic [7:0] SRAP_RST_STATUS = 8'h80;
   localparam logic [23:0] SRAP_RST_MODE = 24'h080060;
   localparam logic [23:0] SRAP_RST_CONFIG = 24'h000117;
   localparam logic [23:0] SRAP_RST_RESULT = 24'h000000;
   localparam logic [7:0] SRAP_RST_GPOUT = 8'h00;
   localparam logic [23:0] SRAP_RST_ZCAL = 24'h800000;
   // arbitrary neutral values
   localparam logic [7:0] SRAP_IDENT_VAL = 8'hA3;
   localparam logic [23:0] SRAP_RST_GCAL = 24'h500000;
   // ************************************************************
   // command fields
   // ************************************************************
   localparam int SRAP_CMD_GATE_BIT = 7;
   localparam int SRAP_CMD_DIR_BIT = 6;
   localparam int SRAP_CMD_SEL_HI = 5;
   localparam int SRAP_CMD_SEL_LO = 3;
   localparam int SRAP_CMD_CONT_BIT = 2;
   localparam logic [7:0] SRAP_CMD_CONT_ENTER = 8'h5C;
   localparam logic [7:0] SRAP_CMD_CONT_EXIT = 8'h58;
   localparam int SRAP_STATUS_RDY_BIT = 7;
   // ************************************************************
   // counts
   // ************************************************************
   localparam logic [5:0] SRAP_RESET_ONES = 6'h28;
   localparam logic [4:0] SRAP_CMD_BITS = 5'h08;
   localparam logic [4:0] SRAP_LONG_BITS = 5'h18;

   typedef enum logic [4:0] {
      SRAP_IDLE = 5'b00001,
      SRAP_CMD = 5'b00010,
      SRAP_WRITE = 5'b00100,
      SRAP_READ = 5'b01000,
      SRAP_CONT = 5'b10000
   } srap_state_e;

   typedef struct packed {
      logic gate;
      logic dir;
      logic [2:0] sel;
      logic cont;
      logic [1:0] zero;
   } srap_cmd_s;

   typedef struct packed {
      logic [23:0] data;
      logic valid;
   } srap_result_s;
endpackage : srap_pkg

// ---- testbench/srap_host.sv ----
`timescale 1ns/1ps
module srap_host (
   output logic sclk, // serial clock to device
   output logic din, // serial data to device
   input wire logic dout // serial data from device
);
   // ************************************************************
   // serial host, link clock stands high between frames
   // ************************************************************
   initial begin
      sclk = 1'b1;
      din = 1'b1;
   end

   task automatic shift(input int n, input logic [23:0] wv, input logic idle, output logic [23:0] rv);
      rv = 24'h000000;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         din = wv[i];
         #62.5;
         sclk = 1'b1;
         rv = {rv[22:0], dout};
         #62.5;
      end
      din = idle;
      #62.5;
   endtask : shift

   task automatic access(input logic [7:0] cmd, input int n, input logic [23:0] wv, output logic [23:0] rv);
      logic [23:0] cv;
      shift(8, {16'h0000, cmd}, 1'b1, cv);
      shift(n, wv, 1'b1, rv);
   endtask : access
endmodule : srap_host

// ---- testbench/serial_register_access_port_tb.sv ----
`timescale 1ns/1ps
module serial_register_access_port_tb;
   import srap_pkg::*;
   logic mclk, rst, sclk, din, dout, rdy_n, part_reset;
   srap_result_s result_in;
   logic [23:0] mode_out, config_out, zcal_out, gcal_out, v;
   logic [7:0] gpout_out;
   logic [23:0] exp_val [4];
   logic [2:0] sel_tab [4];
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   int pulses = 0;

   srap_port srap_port_inst (.mclk(mclk), .rst(rst), .sclk(sclk), .din(din), .dout(dout), .rdy_n(rdy_n),
      .result_in(result_in), .mode_out(mode_out), .config_out(config_out), .gpout_out(gpout_out),
      .zcal_out(zcal_out), .gcal_out(gcal_out), .part_reset(part_reset));
   srap_host srap_host_inst (.sclk(sclk), .din(din), .dout(dout));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (part_reset === 1'b1) begin
         pulses++;
      end
      if (cycles == 30000) begin
         failures++;
         summarize();
      end
   end

   task automatic compare(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare

   task automatic summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   task automatic pulse_result(input logic [23:0] d);
      @(posedge mclk);
      #1;
      result_in = '{data: d, valid: 1'b1};
      @(posedge mclk);
      #1;
      result_in.valid = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      compare({23'h000000, rdy_n}, 24'h000000);
   endtask : pulse_result

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst = 1'b1;
      result_in = '0;
      sel_tab = '{SRAP_ADDR_MODE, SRAP_ADDR_CONFIG, SRAP_ADDR_ZCAL, SRAP_ADDR_GCAL};
      repeat (20) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      compare(mode_out, SRAP_RST_MODE);
      compare(config_out, SRAP_RST_CONFIG);
      compare(zcal_out, SRAP_RST_ZCAL);
      compare(gcal_out, SRAP_RST_GCAL);
      compare({gpout_out, 14'h0000, rdy_n, dout}, {SRAP_RST_GPOUT, 14'h0000, 2'b11});
      srap_host_inst.shift(3, 24'hFFFFFF, 1'b1, v);
      for (int a = 0; a < 4; a++) begin
         exp_val[a] = 24'h5A3C96 + 24'h111111 * a;
         srap_host_inst.access({2'b00, sel_tab[a], 3'b000}, 24, exp_val[a], v);
      end
      compare(mode_out, exp_val[0]);
      compare(config_out, exp_val[1]);
      compare(zcal_out, exp_val[2]);
      compare(gcal_out, exp_val[3]);
      for (int a = 0; a < 4; a++) begin
         srap_host_inst.access({2'b01, sel_tab[a], 3'b000}, 24, 24'h000000, v);
         compare(v, exp_val[a]);
      end
      srap_host_inst.access({2'b00, SRAP_ADDR_GPOUT, 3'b000}, 8, 24'h0000A5, v);
      compare({16'h0000, gpout_out}, 24'h0000A5);
      srap_host_inst.access({2'b01, SRAP_ADDR_GPOUT, 3'b000}, 8, 24'h000000, v);
      compare(v, 24'h0000A5);
      srap_host_inst.access({2'b01, SRAP_ADDR_IDENT, 3'b000}, 8, 24'h000000, v);
      compare(v, {16'h0000, SRAP_IDENT_VAL});
      srap_host_inst.access({2'b00, SRAP_ADDR_STATUS, 3'b000}, 8, 24'h00007F, v);
      srap_host_inst.access({2'b01, SRAP_ADDR_STATUS, 3'b000}, 8, 24'h000000, v);
      compare(v, {16'h0000, SRAP_RST_STATUS});
      pulse_result(24'hC0FFEE);
      srap_host_inst.access({2'b01, SRAP_ADDR_STATUS, 3'b000}, 8, 24'h000000, v);
      compare(v, 24'h000000);
      srap_host_inst.access({2'b01, SRAP_ADDR_RESULT, 3'b000}, 24, 24'h000000, v);
      compare(v, 24'hC0FFEE);
      compare({23'h000000, rdy_n}, 24'h000001);
      // continuous readout, input held low
      srap_host_inst.shift(8, {16'h0000, SRAP_CMD_CONT_ENTER}, 1'b0, v);
      pulse_result(24'h9AB123);
      srap_host_inst.shift(24, 24'h000000, 1'b0, v);
      compare(v, 24'h9AB123);
      // exit command rides on a streamed read
      pulse_result(24'h3C5A69);
      srap_host_inst.shift(24, {SRAP_CMD_CONT_EXIT, 16'h0000}, 1'b1, v);
      compare(v, 24'h3C5A69);
      pulse_result(24'h0F1E2D);
      srap_host_inst.access({2'b01, SRAP_ADDR_STATUS, 3'b000}, 8, 24'h000000, v);
      compare(v, 24'h000000);
      // forty ones recover the part
      srap_host_inst.shift(24, 24'hFFFFFF, 1'b1, v);
      srap_host_inst.shift(16, 24'h00FFFF, 1'b1, v);
      repeat (5) @(posedge mclk);
      #1;
      compare(pulses, 1);
      compare(mode_out, SRAP_RST_MODE);
      compare(gcal_out, SRAP_RST_GCAL);
      srap_host_inst.access({2'b01, SRAP_ADDR_CONFIG, 3'b000}, 24, 24'h000000, v);
      compare(v, SRAP_RST_CONFIG);
      summarize();
   end
endmodule : serial_register_access_port_tb
